// ==== design/igc_top.sv ====
// Ignition gate control block with AHB-Lite register slave.
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module igc_top #(
	parameter int NCH = 4,
	parameter int OS_CYC_10 = igc_pkg::OS_CYC_0,
	parameter int OS_CYC_20 = igc_pkg::OS_CYC_1,
	parameter int OS_CYC_50 = igc_pkg::OS_CYC_2,
	parameter int OS_CYC_100 = igc_pkg::OS_CYC_3
) (
	input wire logic sys_clk, // System clock, 250 MHz.
	input wire logic rstn, // Asynchronous active-low reset.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Always OKAY.
	input wire logic [3:0] gate_cmd_in, // Parallel gate command pins.
	input wire logic [3:0] pwm_in, // Programmed PWM waveform per channel.
	input wire logic [3:0] fb_high_in, // Feedback above supply plus 21 V.
	input wire logic [3:0] fb_end_in, // Feedback above selected end level.
	input wire logic [3:0] fb_135_in, // Primary above 135 V.
	input wire logic nom_cmp_in, // Coil current above nominal threshold.
	input wire logic max_cmp_in, // Coil current above maximum threshold.
	output logic [3:0] gate_drive_out, // Gate drive commands.
	output logic [3:0] lv_clamp_out, // Low-voltage clamp activation.
	output logic spark_duration_out, // Spark duration pulse.
	output logic nominal_current_flag, // Nominal current flag.
	output logic max_current_flag, // Maximum current flag.
	output logic [1:0] end_spark_level_sel, // Level code to the comparator.
	output logic gain_two_out, // Amplifier gain two when high.
	output logic irq // Level interrupt.
);
	// ----------------------------------------------------------------
	// Reset release and input synchronisers.
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	logic srstn;
	logic [17:0] in_s1, in_s2;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign srstn = rst_sync[1];
	// Two flip-flops before logic reads a command, feedback or comparator pin; pwm_in is used directly.
	always_ff @(posedge sys_clk or negedge srstn) begin
		if (!srstn) begin
			in_s1 <= 18'h0;
			in_s2 <= 18'h0;
		end else begin
			in_s1 <= {max_cmp_in, nom_cmp_in, fb_135_in, fb_end_in, fb_high_in, gate_cmd_in};
			in_s2 <= in_s1;
		end
	end
	logic [3:0] cmd_s, fbh_s, fbe_s, f135_s;
	logic nom_s, max_s;
	assign {max_s, nom_s, f135_s, fbe_s, fbh_s, cmd_s} = in_s2;

	// ----------------------------------------------------------------
	// AHB-Lite slave and registers.
	// ----------------------------------------------------------------
	logic [11:0] mode_reg, next_mode_reg;
	igc_pkg::igc_spark_t spark, next_spark;
	logic [3:0] spi_cmd, next_spi_cmd;
	logic [3:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic [3:0] fault, fault_evt;
	logic [3:0] gp;
	assign gp = mode_reg[igc_pkg::MODE_GP_LSB +: 4]; // R15
	// Decodes the address phase and stores write data in the data phase.
	always_comb begin
		next_mode_reg = mode_reg;
		next_spark = spark;
		next_spi_cmd = spi_cmd;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_wr_pend = 1'b0;
		next_wr_addr = wr_addr;
		next_hrdata = hrdata;
		if (wr_pend) begin
			case (wr_addr)
				igc_pkg::ADDR_MODE: next_mode_reg = hwdata[11:0]; // R1
				igc_pkg::ADDR_SPARK: next_spark = hwdata[6:0]; // R13
				igc_pkg::ADDR_CMD: next_spi_cmd = hwdata[3:0];
				igc_pkg::ADDR_IRQ_MASK: next_irq_mask = hwdata[3:0];
				igc_pkg::ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~hwdata[3:0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle.
		next_irq_stat = next_irq_stat | fault_evt;
		if (hsel && hready && htrans[1]) begin
			next_wr_pend = hwrite;
			next_wr_addr = haddr[7:0];
			case (haddr[7:0])
				igc_pkg::ADDR_MODE: next_hrdata = {20'h0, mode_reg};
				igc_pkg::ADDR_SPARK: next_hrdata = {25'h0, spark};
				igc_pkg::ADDR_CMD: next_hrdata = {28'h0, spi_cmd};
				igc_pkg::ADDR_STATUS: next_hrdata = {26'h0, max_s, nom_s, fault};
				igc_pkg::ADDR_IRQ_STAT: next_hrdata = {28'h0, irq_stat};
				igc_pkg::ADDR_IRQ_MASK: next_hrdata = {28'h0, irq_mask};
				default: next_hrdata = 32'h0;
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge srstn) begin
		if (!srstn) begin
			mode_reg <= igc_pkg::MODE_RESET; // R17
			spark <= igc_pkg::SPARK_RESET; // R17
			spi_cmd <= 4'h0;
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h0;
			hrdata <= 32'h0;
		end else begin
			mode_reg <= next_mode_reg;
			spark <= next_spark;
			spi_cmd <= next_spi_cmd;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel ignition control.
	// ----------------------------------------------------------------
	// Fault interval in cycles for a selection code.
	function automatic logic [15:0] os_limit(input logic [1:0] sel);
		case (sel)
			2'b00: os_limit = 16'(OS_CYC_10);
			2'b01: os_limit = 16'(OS_CYC_20);
			2'b10: os_limit = 16'(OS_CYC_50);
			default: os_limit = 16'(OS_CYC_100);
		endcase
	endfunction
	igc_pkg::igc_ch_state_t st [NCH];
	igc_pkg::igc_ch_state_t next_st [NCH];
	logic [15:0] os_cnt [NCH];
	logic [15:0] next_os_cnt [NCH];
	logic [3:0] cmd_q, next_fault, next_gate, next_clamp, spk_on, next_spk_on;
	logic [15:0] lim;
	// Steps each ignition channel through on, spark and lockout.
	always_comb begin
		lim = os_limit(spark.open_secondary_time_sel); // R11
		next_fault = fault;
		fault_evt = 4'h0;
		for (int i = 0; i < NCH; i++) begin
			next_st[i] = st[i];
			next_os_cnt[i] = os_cnt[i];
			next_spk_on[i] = spk_on[i];
			next_clamp[i] = 1'b0;
			if (gp[i]) begin
				// General purpose: serial bit or pin, or PWM; no ignition effects.
				next_gate[i] = spi_cmd[i] | cmd_s[i] | (mode_reg[i] & pwm_in[i]); // R2 R16 R7
				next_st[i] = igc_pkg::CH_IDLE;
				next_os_cnt[i] = 16'h0;
				next_spk_on[i] = 1'b0;
			end else begin
				next_gate[i] = 1'b0;
				if (cmd_s[i] && !cmd_q[i]) next_fault[i] = 1'b0; // R18
				// Spark pulse set at the high level, cleared below end level.
				if (fbh_s[i]) next_spk_on[i] = 1'b1; // R8
				else if (!fbe_s[i]) next_spk_on[i] = 1'b0; // R8
				case (st[i])
					igc_pkg::CH_IDLE: if (cmd_s[i]) next_st[i] = igc_pkg::CH_ON;
					igc_pkg::CH_ON: begin
						next_gate[i] = cmd_s[i]; // R16
						if (!cmd_s[i]) next_st[i] = igc_pkg::CH_SPARK;
						next_os_cnt[i] = 16'h0;
					end
					igc_pkg::CH_SPARK: begin
						if (cmd_s[i]) next_st[i] = igc_pkg::CH_ON;
						else if (f135_s[i]) begin
							next_os_cnt[i] = os_cnt[i] + 16'h1; // R10
							if (os_cnt[i] + 16'h1 >= lim) begin
								next_fault[i] = 1'b1; // R11 R18
								fault_evt[i] = 1'b1;
								if (spark.clamp_en) next_st[i] = igc_pkg::CH_LOCK; // R12
							end
						end else next_os_cnt[i] = 16'h0; // R10
					end
					igc_pkg::CH_LOCK: begin
						// Clamp held and output kept off until input toggles.
						next_clamp[i] = !cmd_s[i]; // R12
						if (cmd_s[i] && !cmd_q[i]) next_st[i] = igc_pkg::CH_ON; // R6
					end
					default: next_st[i] = igc_pkg::CH_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge sys_clk or negedge srstn) begin
		if (!srstn) begin
			for (int i = 0; i < NCH; i++) begin
				st[i] <= igc_pkg::CH_IDLE;
				os_cnt[i] <= 16'h0;
			end
			cmd_q <= 4'h0;
			fault <= 4'h0;
			spk_on <= 4'h0;
			gate_drive_out <= 4'h0;
			lv_clamp_out <= 4'h0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				st[i] <= next_st[i];
				os_cnt[i] <= next_os_cnt[i];
			end
			cmd_q <= cmd_s;
			fault <= next_fault;
			spk_on <= next_spk_on;
			gate_drive_out <= next_gate;
			lv_clamp_out <= next_clamp;
		end
	end

	// ----------------------------------------------------------------
	// Flags, configuration outputs and interrupt.
	// ----------------------------------------------------------------
	// All remaining outputs are registered; the spark pulse and the interrupt are reduced ORs.
	always_ff @(posedge sys_clk or negedge srstn) begin
		if (!srstn) begin
			spark_duration_out <= 1'b0;
			nominal_current_flag <= 1'b0;
			max_current_flag <= 1'b0;
			end_spark_level_sel <= igc_pkg::LVL_5V5;
			gain_two_out <= 1'b0;
			irq <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			spark_duration_out <= |(spk_on & ~gp); // R19 R3
			nominal_current_flag <= nom_s; // R4
			max_current_flag <= max_s; // R4
			end_spark_level_sel <= spark.end_spark_level_sel; // R9
			gain_two_out <= spark.gain_two; // R5
			irq <= |(irq_stat & irq_mask);
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	// Lockout of channel 0 while it is in ignition mode.
	sequence s_lock_ch0;
		st[0] == igc_pkg::CH_LOCK && !gp[0];
	endsequence
	// The fault timer of channel 0 reaches its limit with the clamp enabled.
	sequence s_fault_clamp_ch0;
		st[0] == igc_pkg::CH_SPARK && fault_evt[0] && spark.clamp_en;
	endsequence
	// A rising command pin seen while channel 0 is locked out.
	sequence s_retoggle_ch0;
		s_lock_ch0 ##0 (cmd_s[0] && !cmd_q[0]);
	endsequence
	// With every driver in general-purpose mode the spark pulse stays low.
	property p_gp_no_spark;
		@(posedge sys_clk) disable iff (!srstn)
		(&gp) |=> !spark_duration_out;
	endproperty
	a_gp_no_spark: assert property (p_gp_no_spark) // R19
		else $error("spark pulse with no ignition channel");
	// A locked channel never drives its gate.
	property p_lock_off;
		@(posedge sys_clk) disable iff (!srstn)
		s_lock_ch0 |=> !gate_drive_out[0];
	endproperty
	a_lock_off: assert property (p_lock_off) // R6
		else $error("locked channel drives gate");
	// A locked channel holds its clamp while the pin stays low.
	property p_lock_clamp;
		@(posedge sys_clk) disable iff (!srstn)
		s_lock_ch0 ##0 !cmd_s[0] |=> lv_clamp_out[0];
	endproperty
	a_lock_clamp: assert property (p_lock_clamp) // R12
		else $error("clamp missing in lockout");
	// An expired fault time with the clamp enabled enters lockout.
	property p_fault_lock;
		@(posedge sys_clk) disable iff (!srstn)
		s_fault_clamp_ch0 |=> st[0] == igc_pkg::CH_LOCK;
	endproperty
	a_fault_lock: assert property (p_fault_lock) // R12
		else $error("no lockout after open-secondary fault");
	// A rising command pin releases a locked channel to the on state.
	property p_retoggle;
		@(posedge sys_clk) disable iff (!srstn)
		s_retoggle_ch0 |=> st[0] == igc_pkg::CH_ON;
	endproperty
	a_retoggle: assert property (p_retoggle) // R6
		else $error("locked channel not released by pin");
	// An expired fault time raises the fault flag and the interrupt status.
	property p_fault_flag;
		@(posedge sys_clk) disable iff (!srstn)
		fault_evt[0] |=> fault[0] && irq_stat[0];
	endproperty
	a_fault_flag: assert property (p_fault_flag) // R18
		else $error("fault flag not raised");
	// In the spark state with the pin low, the fault timer restarts when the primary falls below its level.
	property p_os_restart;
		@(posedge sys_clk) disable iff (!srstn)
		(st[0] == igc_pkg::CH_SPARK && !gp[0] && !cmd_s[0] && !f135_s[0])
		|=> os_cnt[0] == 16'h0;
	endproperty
	a_os_restart: assert property (p_os_restart) // R10
		else $error("fault timer not restarted");
	// General-purpose drivers never see the clamp.
	property p_gp_no_clamp;
		@(posedge sys_clk) disable iff (!srstn)
		1'b1 |=> (lv_clamp_out & $past(gp)) == 4'h0;
	endproperty
	a_gp_no_clamp: assert property (p_gp_no_clamp) // R7
		else $error("clamp on a general-purpose driver");
	// The gain output follows the gain select bit one cycle later.
	property p_gain;
		@(posedge sys_clk) disable iff (!srstn)
		1'b1 |=> gain_two_out == $past(spark.gain_two);
	endproperty
	a_gain: assert property (p_gain) // R5
		else $error("gain mismatch");
	// The nominal flag is high one cycle after its comparator is.
	property p_flags;
		@(posedge sys_clk) disable iff (!srstn)
		nom_s |=> nominal_current_flag;
	endproperty
	a_flags: assert property (p_flags) // R4
		else $error("nominal flag missing");
	// The maximum flag tracks its comparator, low and high alike.
	property p_max_flag;
		@(posedge sys_clk) disable iff (!srstn)
		1'b1 |=> max_current_flag == $past(max_s);
	endproperty
	a_max_flag: assert property (p_max_flag) // R4
		else $error("maximum flag mismatch");
	// The slave never stalls and always answers OKAY.
	property p_bus_okay;
		@(posedge sys_clk) disable iff (!srstn)
		hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay)
		else $error("bus stall or error response");
endmodule
`default_nettype wire

// ==== inc/igc_pkg.sv ====
// Package with constants, layouts and types of the ignition gate control block.
// Behaviour
// R1: Mode word bits 0 to 3 enable the PWM generator of gate drivers 0 to 3.
// R2: A programmed general-purpose channel runs PWM while enabled, stops when cleared.
// R3: Each driver is configured for ignition on its own; ignition features apply there only.
// R4: Nominal and maximum current flags are low below threshold, high above it.
// R5: Gain select bit one chooses gain two, zero chooses gain one, the default.
// R6: A gate output shut off by ignition strategy stays off until its input toggles.
// R7: Ignition settings have no effect on general-purpose drivers.
// R8: Spark pulse starts above supply plus 21 V, ends below end-of-spark level.
// R9: Bits 1:0 pick end-of-spark level 2.75, 5.5, 8.2 or 11.0 V above supply.
// R10: Open-secondary timer runs between rising and falling 135 V primary crossings.
// R11: Bits 3:2 pick fault time 10, 20, 50 or 100 us; longer clamp fails spark.
// R12: Fault time exceeded with clamp enabled activates the low-voltage clamp.
// R13: Bit 4 of the ignition word enables the low-voltage clamp.
// R14: The processor times the spark pulse width and adjusts dwell.
// R15: Mode bits 8 to 11 set drivers 0 to 3; zero ignition, one general purpose.
// R16: The command bit drives a gate only in general-purpose mode.
// R17: Reset gives ignition mode, 100 us fault time, 5.5 V level, clamp off.
// R18: Fault timer counts clock cycles, flags at interval, clears on next turn-on.
// R19: Spark output stays low unless some driver is in ignition mode.
package igc_pkg;
	// ----------------------------------------------------------------
	// Bus register map.
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_SPARK = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int MODE_PWM_LSB = 0;
	localparam int MODE_GP_LSB = 8;
	localparam int SPK_END_LSB = 0;
	localparam int SPK_OS_LSB = 2;
	localparam int SPK_CLAMP_BIT = 4;
	localparam int SPK_GAIN_BIT = 6;
	localparam logic [11:0] MODE_RESET = 12'h000;
	localparam logic [6:0] SPARK_RESET = 7'h0d;
	// ----------------------------------------------------------------
	// Timing: fault times in microseconds and the clock rate.
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int OS_US_0 = 10;
	localparam int OS_US_1 = 20;
	localparam int OS_US_2 = 50;
	localparam int OS_US_3 = 100;
	localparam int OS_CYC_0 = OS_US_0 * CLK_MHZ;
	localparam int OS_CYC_1 = OS_US_1 * CLK_MHZ;
	localparam int OS_CYC_2 = OS_US_2 * CLK_MHZ;
	localparam int OS_CYC_3 = OS_US_3 * CLK_MHZ;
	// ----------------------------------------------------------------
	// Types.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LVL_2V75 = 2'b00,
		LVL_5V5 = 2'b01,
		LVL_8V2 = 2'b10,
		LVL_11V0 = 2'b11
	} igc_end_level_t;
	typedef struct packed {
		logic gain_two;
		logic unused5;
		logic clamp_en;
		logic [1:0] open_secondary_time_sel;
		igc_end_level_t end_spark_level_sel;
	} igc_spark_t;
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_ON = 2'b01,
		CH_SPARK = 2'b10,
		CH_LOCK = 2'b11
	} igc_ch_state_t;
endpackage

// ==== bench/igc_mcu_capture.sv ====
// Controller model that times the spark duration pulse of the block.
`timescale 1ns/1ns
`default_nettype none
module igc_mcu_capture (
	input wire logic sys_clk, // System clock.
	input wire logic rstn, // Active-low reset.
	input wire logic spark_duration_out, // Spark pulse from the block.
	output logic [15:0] spark_width // Width of the last pulse in cycles.
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic [15:0] next_width;
	// Counts high cycles and keeps the total once the pulse falls.
	always_comb begin
		next_count = spark_duration_out ? count + 16'h0001 : 16'h0000;
		next_width = (!spark_duration_out && count != 16'h0000) ? count : spark_width;
	end
	// Registers the counter and the captured width.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count <= 16'h0000;
			spark_width <= 16'h0000;
		end else begin
			count <= next_count;
			spark_width <= next_width;
		end
	end
endmodule
`default_nettype wire

// ==== bench/test_ignition_gate_control.sv ====
// Self-checking testbench of the ignition gate control block.
`timescale 1ns/1ns
`default_nettype none
module test_ignition_gate_control;
	typedef struct packed {
		logic [6:0] spk;
		logic nom;
		logic mx;
		logic [1:0] lvl;
		logic gain;
	} igc_tb_row_t;
	logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0, nom = 0, mx = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, lvl;
	logic [2:0] hsize = 3'h2;
	logic [3:0] cmd = 0, pwm = 0, fbh = 0, fbe = 0, fb135 = 0, gate, clamp;
	logic hreadyout, hresp, spark, nflag, mflag, gain, irq;
	logic [15:0] width;
	int n_errors = 0, total_checks = 0;
	igc_tb_row_t rows [4] = '{'{7'h00, 1, 0, 2'h0, 0}, '{7'h41, 0, 1, 2'h1, 1},
		'{7'h02, 1, 1, 2'h2, 0}, '{7'h43, 0, 0, 2'h3, 1}};
	igc_top #(.OS_CYC_10(4), .OS_CYC_20(8), .OS_CYC_50(16), .OS_CYC_100(32)) igc_top_inst (
		.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .gate_cmd_in(cmd), .pwm_in(pwm),
		.fb_high_in(fbh), .fb_end_in(fbe), .fb_135_in(fb135), .nom_cmp_in(nom),
		.max_cmp_in(mx), .gate_drive_out(gate), .lv_clamp_out(clamp),
		.spark_duration_out(spark), .nominal_current_flag(nflag), .max_current_flag(mflag),
		.end_spark_level_sel(lvl), .gain_two_out(gain), .irq(irq));
	igc_mcu_capture igc_mcu_capture_inst (.sys_clk(sys_clk), .rstn(rstn),
		.spark_duration_out(spark), .spark_width(width));
	// Clock of 4 ns period.
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// Waits whole cycles and returns on a rising edge: the bench drives there
	// and reads outputs that have stood since the edge before.
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Compares a value and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (exp !== got) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One AHB-Lite single word transfer; read data taken at the data phase edge.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		hwrite <= 0;
	endtask
	// Ends the run with the counts and the verdict.
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog that cuts a hang short.
	initial begin
		#40000;
		n_errors++;
		report_and_stop();
	end
	// Main sequence.
	initial begin
		cyc(6);
		rstn <= 1;
		cyc(4);
		chk("lvl_rst", 1, lvl);
		chk("gain_rst", 0, gain);
		ahb(0, 8'h00, 0);
		chk("mode_rst", 0, rd);
		ahb(0, 8'h04, 0);
		chk("spark_rst", 32'h0000000d, rd);
		foreach (rows[i]) begin
			ahb(1, 8'h04, rows[i].spk);
			nom <= rows[i].nom;
			mx <= rows[i].mx;
			cyc(8);
			chk("lvl", rows[i].lvl, lvl);
			chk("gain", rows[i].gain, gain);
			chk("nom", rows[i].nom, nflag);
			chk("max", rows[i].mx, mflag);
		end
		ahb(0, 8'h20, 0);
		chk("unmapped", 0, rd);
		ahb(1, 8'h08, 32'h2);
		cmd <= 4'h1;
		cyc(8);
		chk("gate_ign", 4'h1, gate);
		ahb(1, 8'h08, 0);
		ahb(1, 8'h00, 32'h202);
		pwm <= 4'h2;
		cyc(8);
		chk("gate_pwm_on", 4'h3, gate);
		ahb(1, 8'h00, 32'h200);
		cyc(8);
		chk("gate_pwm_off", 4'h1, gate);
		ahb(1, 8'h08, 32'h2);
		cyc(8);
		chk("gate_serial", 4'h3, gate);
		ahb(1, 8'h08, 0);
		cmd <= 0;
		fbh <= 4'h2;
		fbe <= 4'h2;
		cyc(10);
		chk("spark_gp", 0, spark);
		fbh <= 4'h1;
		fbe <= 4'h1;
		cyc(10);
		fbh <= 0;
		cyc(10);
		chk("spark_hold", 1, spark);
		fbe <= 0;
		cyc(10);
		chk("spark_width", 20, width);
		// Every driver in general-purpose mode: feedback must not make a pulse.
		ahb(1, 8'h00, 32'hf00);
		fbh <= 4'hf;
		fbe <= 4'hf;
		cyc(10);
		chk("spark_all_gp", 0, spark);
		fbh <= 0;
		fbe <= 0;
		ahb(1, 8'h00, 32'h200);
		ahb(1, 8'h04, 32'h1c);
		cmd <= 4'h3;
		cyc(8);
		cmd <= 0;
		fb135 <= 4'h3;
		cyc(8);
		fb135 <= 0;
		cyc(8);
		chk("no_fault", 0, clamp);
		ahb(1, 8'h04, 32'h10);
		cmd <= 4'h3;
		cyc(8);
		cmd <= 0;
		fb135 <= 4'h3;
		cyc(20);
		chk("clamp", 4'h1, clamp);
		fb135 <= 0;
		cyc(10);
		chk("gate_lock", 0, gate);
		ahb(0, 8'h0c, 0);
		chk("fault_flag", 1, rd[3:0]);
		chk("irq_masked", 0, irq);
		ahb(0, 8'h10, 0);
		chk("irq_stat", 1, rd[3:0]);
		ahb(1, 8'h14, 32'h1);
		cyc(3);
		chk("irq_on", 1, irq);
		ahb(1, 8'h10, 32'h1);
		cyc(3);
		chk("irq_clear", 0, irq);
		cmd <= 4'h1;
		cyc(8);
		chk("gate_retoggle", 4'h1, gate);
		chk("clamp_off", 0, clamp);
		ahb(0, 8'h0c, 0);
		chk("fault_clear", 0, rd[3:0]);
		// Mid-run reset puts outputs and configuration back to their defaults.
		rstn <= 0;
		cyc(2);
		chk("gate_in_rst", 0, gate);
		chk("clamp_in_rst", 0, clamp);
		rstn <= 1;
		cyc(4);
		chk("lvl_rst2", 1, lvl);
		ahb(0, 8'h04, 0);
		chk("spark_rst2", 32'h0000000d, rd);
		ahb(0, 8'h00, 0);
		chk("mode_rst2", 0, rd);
		chk("hresp", 0, hresp);
		chk("hready", 1, hreadyout);
		report_and_stop();
	end
endmodule
`default_nettype wire
